// ### logic/scpc_map.svh
// Register offsets, field positions, reset values and timing counts of the clock and power control block
`ifndef SCPC_MAP_SVH
`define SCPC_MAP_SVH

`define SCPC_CAP_MASK_1_OFF 12'h010
`define SCPC_CAP_MASK_2_OFF 12'h014
`define SCPC_CAP_MASK_4_OFF 12'h01C
`define SCPC_REG_POWER_CTL_OFF 12'h034
`define SCPC_RAW_STATUS_OFF 12'h050
`define SCPC_RUN_CLOCK_CONFIG_OFF 12'h060
`define SCPC_PLL_TRANSLATION_OFF 12'h064
`define SCPC_RUN_GATE_OFF 12'h100
`define SCPC_SLEEP_GATE_OFF 12'h110
`define SCPC_DEEP_GATE_OFF 12'h120
`define SCPC_DEEP_SLEEP_CLOCK_CONFIG_OFF 12'h144
`define SCPC_CLOCK_VERIFY_CLEAR_OFF 12'h150
`define SCPC_REG_LOSS_RESET_OFF 12'h160

`define SCPC_RUN_CLOCK_CONFIG_RST 32'h07A03AD1
`define SCPC_DEEP_SLEEP_CLOCK_CONFIG_RST 32'h07800000
`define SCPC_CAP_MASK_1_VAL 32'h000132BF
`define SCPC_CAP_MASK_2_VAL 32'h01071013
`define SCPC_CAP_MASK_4_VAL 32'h0000001F
`define SCPC_GATE0_RST 32'h00000040
`define SCPC_GATE_RST 32'h00000000

`define SCPC_PLL_CHECK_BIT 1
`define SCPC_INT_CHECK_BIT 2
`define SCPC_MAIN_CHECK_BIT 3
`define SCPC_OSC_SRC_LSB 4
`define SCPC_CRYSTAL_LSB 6
`define SCPC_BYPASS_BIT 11
`define SCPC_PLL_OUT_DIS_BIT 12
`define SCPC_PLL_PD_BIT 13
`define SCPC_USE_SYSTEM_DIVIDER_BIT 22
`define SCPC_SYSTEM_DIVIDER_LSB 23
`define SCPC_AUTO_GATE_BIT 27
`define SCPC_DSLP_INT_OSC_BIT 4
`define SCPC_LOCK_STATUS_BIT 6
`define SCPC_FAIL_STATUS_LSB 8
`define SCPC_REGULATOR_VOLTAGE_ADJUST_W 6

`define SCPC_SRC_MAIN 2'h0
`define SCPC_SRC_INT 2'h1
`define SCPC_SRC_INT4 2'h2
`define SCPC_SRC_PLL 2'h3
`define SCPC_DIV_ONE 7'h01
`define SCPC_DIV_DEEP_MAIN 7'h10
`define SCPC_DIV_DEEP_INT 7'h40

`define SCPC_RELOCK_LOAD 16'h1200
`define SCPC_MON_MIN_EDGES 1
`define SCPC_ADC_DIV 12
`define SCPC_SWITCH_GAP 3'h4
`define SCPC_REG_RESET_CYCLES 5'h10

`endif

// ### logic/scpc_pkg.sv
// Types shared by the clock and power control block
package scpc_pkg;
	typedef struct packed {
		logic [1:0] src;
		logic [6:0] div;
		logic run;
	} scpc_clk_sel_t;
	typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP, MODE_WAKE} scpc_mode_t;
	typedef enum logic [1:0] {SW_IDLE, SW_STOP, SW_GO} scpc_sw_t;
endpackage

// ### logic/scpc_top.sv
// Clock source selection, PLL relock, clock monitors, power modes and gating with an APB register file
// Behaviour
// - Unregulated regulator with enable set pulses internal reset; enable clears in the same cycle the pulse starts.
// - Regulator voltage adjust field drives the core voltage setting, 2.25 V to 2.75 V.
// - System clock from main osc, internal osc, PLL, or internal osc divided by four.
// - Converter clock tick is a fixed division of the PLL output.
// - Crystal change updates the read-only PLL translation value.
// - PLL stays powered down after reset until software enables it.
// - Normal mode drives PLL output; power-down mode stops it.
// - Crystal value change or power-down exit starts relock; same value does not.
// - Relock counter loads 0x1200, counts main osc edges down to zero.
// - PLL cannot be the system clock until relock expires.
// - Three identical monitors: main checks PLL, main checks internal, internal/64 checks main.
// - Enabled monitor failure switches to a working clock and raises the interrupt.
// - Failure and forced switch stay until verify clear write or reset.
// - Each monitor has its own enable bit in the run clock config.
// - Peripheral gates come from run, sleep or deep-sleep gating per mode.
// - Capability masks limit which gating bits writes can set.
// - Sleep stops core clock, gates peripherals per auto gating, keeps system clock.
// - Wait-for-interrupt enters sleep; any wake event returns to run.
// - Deep sleep runs main osc or internal osc per config, powering main down only when running internal osc.
// - Running PLL is powered down in deep sleep, and only then is the divider forced to /16 or /64.
// - Deep sleep exit restores entry clock before stopped clocks restart.
// - PLL lock shows in raw status; software waits for it before leaving bypass.
`timescale 1ns/10ps
`include "scpc_map.svh"
module scpc_top import scpc_pkg::*; #(
	parameter int RELOCK_LOAD = `SCPC_RELOCK_LOAD,
	parameter int MON_MIN = `SCPC_MON_MIN_EDGES,
	parameter int ADC_DIV = `SCPC_ADC_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic main_osc_in,
	input wire logic int_osc_in,
	input wire logic pll_in,
	input wire logic regulator_unregulated,
	input wire logic wait_for_interrupt_instr,
	input wire logic deep_sleep_enable,
	input wire logic wake_event,
	output scpc_clk_sel_t sys_clk_sel,
	output logic core_clk_en,
	output logic [2:0][31:0] periph_clk_en,
	output logic pll_power_down,
	output logic pll_output_enable,
	output logic main_osc_power_down,
	output logic [`SCPC_REGULATOR_VOLTAGE_ADJUST_W-1:0] regulator_voltage_adjust,
	output logic sys_reset_req,
	output logic clk_fail_irq,
	output logic adc_clk_tick
);
	function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
		return (a[11:4] == base[11:4]) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic [31:0] translate(input logic [3:0] crystal_select);
		return {18'h0, 9'({crystal_select, 1'b0}) + 9'h020, 5'h01};
	endfunction

	logic [31:0] run_clock_config_r;
	logic [31:0] deep_sleep_clock_config_r;
	logic [31:0] pll_translation_r;
	logic [`SCPC_REGULATOR_VOLTAGE_ADJUST_W-1:0] regulator_power_ctl_r;
	logic regulator_loss_reset_enable_r;
	logic [2:0][31:0] run_gate_ctl_r;
	logic [2:0][31:0] sleep_gate_ctl_r;
	logic [2:0][31:0] deep_sleep_gate_ctl_r;
	logic [2:0][31:0] cap_mask;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	logic [3:0] edge_s;
	logic [15:0] relock_cnt_r;
	logic pd_prev_r;
	logic pll_pd_eff;
	logic relock_trig;
	logic pll_ready;
	logic [5:0] int64_cnt_r;
	logic int64_tick;
	logic [2:0] fail_s;
	logic [2:0] mon_fast;
	logic [2:0] mon_slow;
	logic [2:0] mon_en;
	logic verify_clear;
	scpc_mode_t mode_r;
	logic deep_pll_off_r;
	logic [1:0] entry_src_r;
	scpc_sw_t sw_r;
	logic [2:0] sw_cnt_r;
	scpc_clk_sel_t sel_r;
	logic [1:0] tgt_src;
	logic [6:0] tgt_div;
	logic core_clk_en_r;
	logic [2:0][31:0] periph_r;
	logic pll_power_down_r;
	logic pll_output_enable_r;
	logic main_osc_power_down_r;
	logic [4:0] ldo_cnt_r;
	logic sys_reset_req_r;
	logic clk_fail_irq_r;
	logic [7:0] adc_cnt_r;
	logic adc_tick_r;
	logic wr_s;
	logic wr_cfg;
	logic [31:0] rd_data;
	logic rd_ok;
	logic dslp_int;
	logic auto_gate;

	assign cap_mask = {`SCPC_CAP_MASK_4_VAL, `SCPC_CAP_MASK_2_VAL, `SCPC_CAP_MASK_1_VAL};
	assign wr_s = psel & penable & pready_r & pwrite;
	assign wr_cfg = wr_s && (paddr == `SCPC_RUN_CLOCK_CONFIG_OFF);
	assign verify_clear = wr_s && (paddr == `SCPC_CLOCK_VERIFY_CLEAR_OFF) && pwdata[0];
	assign dslp_int = deep_sleep_clock_config_r[`SCPC_DSLP_INT_OSC_BIT];
	assign auto_gate = run_clock_config_r[`SCPC_AUTO_GATE_BIT];

	// Oscillator and regulator pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			prev_r <= 4'h0;
		end else begin
			sync1_r <= {regulator_unregulated, pll_in, int_osc_in, main_osc_in};
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	assign edge_s = sync2_r & ~prev_r;

	// APB read decode
	always_comb begin
		rd_data = 32'h0;
		rd_ok = 1'b1;
		if (in_bank(paddr, `SCPC_RUN_GATE_OFF)) begin
			rd_data = run_gate_ctl_r[paddr[3:2]];
		end else if (in_bank(paddr, `SCPC_SLEEP_GATE_OFF)) begin
			rd_data = sleep_gate_ctl_r[paddr[3:2]];
		end else if (in_bank(paddr, `SCPC_DEEP_GATE_OFF)) begin
			rd_data = deep_sleep_gate_ctl_r[paddr[3:2]];
		end else begin
			case (paddr)
				`SCPC_CAP_MASK_1_OFF: rd_data = cap_mask[0];
				`SCPC_CAP_MASK_2_OFF: rd_data = cap_mask[1];
				`SCPC_CAP_MASK_4_OFF: rd_data = cap_mask[2];
				`SCPC_REG_POWER_CTL_OFF: rd_data = {26'h0, regulator_power_ctl_r};
				`SCPC_RAW_STATUS_OFF: begin
					rd_data[`SCPC_LOCK_STATUS_BIT] = pll_ready;
					rd_data[`SCPC_FAIL_STATUS_LSB +: 3] = fail_s;
				end
				`SCPC_RUN_CLOCK_CONFIG_OFF: rd_data = run_clock_config_r;
				`SCPC_PLL_TRANSLATION_OFF: rd_data = pll_translation_r;
				`SCPC_DEEP_SLEEP_CLOCK_CONFIG_OFF: rd_data = deep_sleep_clock_config_r;
				`SCPC_CLOCK_VERIFY_CLEAR_OFF: rd_data = 32'h0;
				`SCPC_REG_LOSS_RESET_OFF: rd_data = {31'h0, regulator_loss_reset_enable_r};
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= psel & ~penable;
			pslverr_r <= psel & ~penable & ~rd_ok;
			if (psel && !penable) begin
				prdata_r <= pwrite ? 32'h0 : rd_data;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_clock_config_r <= `SCPC_RUN_CLOCK_CONFIG_RST;
			deep_sleep_clock_config_r <= `SCPC_DEEP_SLEEP_CLOCK_CONFIG_RST;
			regulator_power_ctl_r <= '0;
			pll_translation_r <= translate(4'(`SCPC_RUN_CLOCK_CONFIG_RST >> `SCPC_CRYSTAL_LSB));
		end else if (wr_s) begin
			if (paddr == `SCPC_RUN_CLOCK_CONFIG_OFF) begin
				run_clock_config_r <= pwdata;
				pll_translation_r <= translate(pwdata[`SCPC_CRYSTAL_LSB +: 4]);
			end
			if (paddr == `SCPC_DEEP_SLEEP_CLOCK_CONFIG_OFF) begin
				deep_sleep_clock_config_r <= pwdata;
			end
			if (paddr == `SCPC_REG_POWER_CTL_OFF) begin
				regulator_power_ctl_r <= pwdata[`SCPC_REGULATOR_VOLTAGE_ADJUST_W-1:0];
			end
		end
	end

	// Gating registers under capability masks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_gate_ctl_r <= {`SCPC_GATE_RST, `SCPC_GATE_RST, `SCPC_GATE0_RST};
			sleep_gate_ctl_r <= {`SCPC_GATE_RST, `SCPC_GATE_RST, `SCPC_GATE0_RST};
			deep_sleep_gate_ctl_r <= {`SCPC_GATE_RST, `SCPC_GATE_RST, `SCPC_GATE0_RST};
		end else if (wr_s) begin
			if (in_bank(paddr, `SCPC_RUN_GATE_OFF)) begin
				run_gate_ctl_r[paddr[3:2]] <= pwdata & cap_mask[paddr[3:2]];
			end
			if (in_bank(paddr, `SCPC_SLEEP_GATE_OFF)) begin
				sleep_gate_ctl_r[paddr[3:2]] <= pwdata & cap_mask[paddr[3:2]];
			end
			if (in_bank(paddr, `SCPC_DEEP_GATE_OFF)) begin
				deep_sleep_gate_ctl_r[paddr[3:2]] <= pwdata & cap_mask[paddr[3:2]];
			end
		end
	end

	// Regulator loss reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regulator_loss_reset_enable_r <= 1'b0;
			sys_reset_req_r <= 1'b0;
			ldo_cnt_r <= 5'h0;
		end else begin
			if (sys_reset_req_r) begin
				ldo_cnt_r <= ldo_cnt_r - 5'h1;
				if (ldo_cnt_r == 5'h1) begin
					sys_reset_req_r <= 1'b0;
				end
			end else if (regulator_loss_reset_enable_r && sync2_r[3]) begin
				sys_reset_req_r <= 1'b1;
				ldo_cnt_r <= `SCPC_REG_RESET_CYCLES;
				regulator_loss_reset_enable_r <= 1'b0;
			end else if (wr_s && paddr == `SCPC_REG_LOSS_RESET_OFF) begin
				regulator_loss_reset_enable_r <= pwdata[0];
			end
		end
	end

	// PLL relock timing
	assign pll_pd_eff = run_clock_config_r[`SCPC_PLL_PD_BIT] | deep_pll_off_r;
	assign relock_trig = (wr_cfg && pwdata[`SCPC_CRYSTAL_LSB +: 4] != run_clock_config_r[`SCPC_CRYSTAL_LSB +: 4])
		|| (pd_prev_r && !pll_pd_eff);
	assign pll_ready = (relock_cnt_r == 16'h0) && !pd_prev_r && !pll_pd_eff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relock_cnt_r <= 16'h0;
			pd_prev_r <= 1'b1;
		end else begin
			pd_prev_r <= pll_pd_eff;
			if (relock_trig) begin
				relock_cnt_r <= 16'(RELOCK_LOAD);
			end else if (edge_s[0] && relock_cnt_r != 16'h0) begin
				relock_cnt_r <= relock_cnt_r - 16'h1;
			end
		end
	end

	// Clock monitors
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int64_cnt_r <= 6'h0;
		end else if (edge_s[1]) begin
			int64_cnt_r <= int64_cnt_r + 6'h1;
		end
	end
	assign int64_tick = edge_s[1] && (int64_cnt_r == 6'h3F);
	assign mon_fast = {edge_s[0], edge_s[1], edge_s[2]};
	assign mon_slow = {int64_tick, edge_s[0], edge_s[0]};
	assign mon_en = {run_clock_config_r[`SCPC_MAIN_CHECK_BIT], run_clock_config_r[`SCPC_INT_CHECK_BIT],
		run_clock_config_r[`SCPC_PLL_CHECK_BIT] & pll_ready};

	for (genvar m = 0; m < 3; m++) begin : g_mon
		logic [7:0] cnt_r;
		logic fail_r;
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_r <= 8'h0;
				fail_r <= 1'b0;
			end else begin
				fail_r <= (mon_en[m] && mon_slow[m] && cnt_r < 8'(MON_MIN)) || (fail_r && !verify_clear);
				if (mon_slow[m]) begin
					cnt_r <= 8'h0;
				end else if (mon_fast[m] && cnt_r != 8'hFF) begin
					cnt_r <= cnt_r + 8'h1;
				end
			end
		end
		assign fail_s[m] = fail_r;
	end

	// Target source and divider
	always_comb begin
		tgt_src = run_clock_config_r[`SCPC_OSC_SRC_LSB +: 2];
		if (tgt_src == `SCPC_SRC_PLL) begin
			tgt_src = `SCPC_SRC_MAIN;
		end
		if (!run_clock_config_r[`SCPC_BYPASS_BIT] && pll_ready) begin
			tgt_src = `SCPC_SRC_PLL;
		end
		tgt_div = run_clock_config_r[`SCPC_USE_SYSTEM_DIVIDER_BIT] ?
			{3'h0, run_clock_config_r[`SCPC_SYSTEM_DIVIDER_LSB +: 4]} + 7'h01 : `SCPC_DIV_ONE;
		if (mode_r == MODE_DEEP) begin
			tgt_src = dslp_int ? `SCPC_SRC_INT : `SCPC_SRC_MAIN;
			if (deep_pll_off_r) begin
				tgt_div = dslp_int ? `SCPC_DIV_DEEP_INT : `SCPC_DIV_DEEP_MAIN;
			end
		end
		if (fail_s[0] && tgt_src == `SCPC_SRC_PLL) begin
			tgt_src = fail_s[2] ? `SCPC_SRC_INT : `SCPC_SRC_MAIN;
		end
		if (fail_s[2] && (tgt_src == `SCPC_SRC_MAIN || tgt_src == `SCPC_SRC_PLL)) begin
			tgt_src = `SCPC_SRC_INT;
		end
		if (fail_s[1] && (tgt_src == `SCPC_SRC_INT || tgt_src == `SCPC_SRC_INT4)) begin
			tgt_src = `SCPC_SRC_MAIN;
		end
	end

	// Glitch-free switch: stop, change, restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_r <= SW_IDLE;
			sw_cnt_r <= 3'h0;
			sel_r <= '{src: `SCPC_SRC_INT, div: `SCPC_DIV_ONE, run: 1'b1};
		end else begin
			case (sw_r)
				SW_IDLE: begin
					if (tgt_src != sel_r.src || tgt_div != sel_r.div) begin
						sel_r.run <= 1'b0;
						sw_cnt_r <= `SCPC_SWITCH_GAP;
						sw_r <= SW_STOP;
					end
				end
				SW_STOP: begin
					sw_cnt_r <= sw_cnt_r - 3'h1;
					if (sw_cnt_r == 3'h1) begin
						sel_r.src <= tgt_src;
						sel_r.div <= tgt_div;
						sw_cnt_r <= `SCPC_SWITCH_GAP;
						sw_r <= SW_GO;
					end
				end
				SW_GO: begin
					sw_cnt_r <= sw_cnt_r - 3'h1;
					if (sw_cnt_r == 3'h1) begin
						sel_r.run <= 1'b1;
						sw_r <= SW_IDLE;
					end
				end
				default: sw_r <= SW_IDLE;
			endcase
		end
	end

	// Power modes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= MODE_RUN;
			deep_pll_off_r <= 1'b0;
			entry_src_r <= `SCPC_SRC_INT;
		end else begin
			case (mode_r)
				MODE_RUN: begin
					if (wait_for_interrupt_instr) begin
						mode_r <= deep_sleep_enable ? MODE_DEEP : MODE_SLEEP;
						deep_pll_off_r <= deep_sleep_enable && !run_clock_config_r[`SCPC_PLL_PD_BIT];
						entry_src_r <= sel_r.src;
					end
				end
				MODE_SLEEP: begin
					if (wake_event) begin
						mode_r <= MODE_RUN;
					end
				end
				MODE_DEEP: begin
					if (wake_event) begin
						mode_r <= MODE_WAKE;
						deep_pll_off_r <= 1'b0;
					end
				end
				MODE_WAKE: begin
					if (sw_r == SW_IDLE && sel_r.run && (sel_r.src == entry_src_r || fail_s != 3'h0)) begin
						mode_r <= MODE_RUN;
					end
				end
				default: mode_r <= MODE_RUN;
			endcase
		end
	end

	// Clock enables and analog controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_clk_en_r <= 1'b1;
			periph_r <= {`SCPC_GATE_RST, `SCPC_GATE_RST, `SCPC_GATE0_RST};
			pll_power_down_r <= 1'b1;
			pll_output_enable_r <= 1'b0;
			main_osc_power_down_r <= 1'b0;
			clk_fail_irq_r <= 1'b0;
		end else begin
			core_clk_en_r <= (mode_r == MODE_RUN);
			case (mode_r)
				MODE_SLEEP: periph_r <= auto_gate ? sleep_gate_ctl_r : run_gate_ctl_r;
				MODE_DEEP, MODE_WAKE: periph_r <= auto_gate ? deep_sleep_gate_ctl_r : run_gate_ctl_r;
				default: periph_r <= run_gate_ctl_r;
			endcase
			pll_power_down_r <= pll_pd_eff;
			pll_output_enable_r <= !pll_pd_eff && !run_clock_config_r[`SCPC_PLL_OUT_DIS_BIT];
			main_osc_power_down_r <= (mode_r == MODE_DEEP) && dslp_int;
			clk_fail_irq_r <= (fail_s != 3'h0);
		end
	end

	// Converter clock tick from PLL edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_cnt_r <= 8'h0;
			adc_tick_r <= 1'b0;
		end else begin
			adc_tick_r <= 1'b0;
			if (pll_output_enable_r && edge_s[2]) begin
				if (adc_cnt_r == 8'(ADC_DIV - 1)) begin
					adc_cnt_r <= 8'h0;
					adc_tick_r <= 1'b1;
				end else begin
					adc_cnt_r <= adc_cnt_r + 8'h1;
				end
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign sys_clk_sel = sel_r;
	assign core_clk_en = core_clk_en_r;
	assign periph_clk_en = periph_r;
	assign pll_power_down = pll_power_down_r;
	assign pll_output_enable = pll_output_enable_r;
	assign main_osc_power_down = main_osc_power_down_r;
	assign regulator_voltage_adjust = regulator_power_ctl_r;
	assign sys_reset_req = sys_reset_req_r;
	assign clk_fail_irq = clk_fail_irq_r;
	assign adc_clk_tick = adc_tick_r;
endmodule

// ### bench/scpc_chk.sv
// Assertions on the ports of the clock and power control block
`timescale 1ns/10ps
module scpc_chk import scpc_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic wait_for_interrupt_instr,
	input wire logic deep_sleep_enable,
	input wire logic wake_event,
	input wire scpc_clk_sel_t sys_clk_sel,
	input wire logic core_clk_en,
	input wire logic pll_power_down,
	input wire logic pll_output_enable,
	input wire logic main_osc_power_down,
	input wire logic sys_reset_req,
	input wire logic clk_fail_irq
);
	logic clr_wr;
	assign clr_wr = psel && penable && pready && pwrite && paddr == 12'h150 && pwdata[0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	apb_err_a: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access");
	reset_len_a: assert property ($rose(sys_reset_req) |->
		sys_reset_req [*8] ##1 sys_reset_req [*8] ##1 !sys_reset_req) else $error("reset pulse length");
	pll_out_a: assert property (pll_power_down && $past(pll_power_down) |-> !pll_output_enable)
		else $error("pll output while down");
	run_gap_a: assert property ($fell(sys_clk_sel.run) |-> (!sys_clk_sel.run) [*8] ##1 sys_clk_sel.run)
		else $error("clock stop length");
	src_hold_a: assert property ($changed(sys_clk_sel.src) || $changed(sys_clk_sel.div) |->
		!sys_clk_sel.run && !$past(sys_clk_sel.run)) else $error("source changed while running");
	sleep_core_a: assert property (wait_for_interrupt_instr && core_clk_en |-> ##1 core_clk_en ##1 !core_clk_en)
		else $error("core clock not stopped");
	sleep_clk_a: assert property (wait_for_interrupt_instr && !deep_sleep_enable && core_clk_en |=>
		$stable(sys_clk_sel) [*4]) else $error("clock changed in sleep");
	wake_run_a: assert property (wake_event && !core_clk_en |-> ##[1:1000] core_clk_en)
		else $error("no return to run");
	fail_sw_a: assert property ($rose(clk_fail_irq) && sys_clk_sel.src == 2'h1 |->
		##[0:10] sys_clk_sel.src == 2'h0) else $error("no failover");
	fail_hold_a: assert property ($fell(clk_fail_irq) |-> $past(clr_wr, 2))
		else $error("failure cleared without clear write");
	main_pd_a: assert property (main_osc_power_down |-> !core_clk_en)
		else $error("main osc down outside deep sleep");
endmodule
bind scpc_top scpc_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.wait_for_interrupt_instr, .deep_sleep_enable, .wake_event, .sys_clk_sel, .core_clk_en, .pll_power_down,
	.pll_output_enable, .main_osc_power_down, .sys_reset_req, .clk_fail_irq);

// ### bench/scpc_core_model.sv
// Oscillators and processor core facing the clock and power control block
`timescale 1ns/10ps
module scpc_core_model (
	input wire logic pclk,
	input wire logic pll_power_down,
	input wire logic main_osc_power_down,
	input wire logic int_osc_stop,
	output logic main_osc_in,
	output logic int_osc_in,
	output logic pll_in,
	output logic wait_for_interrupt_instr,
	output logic deep_sleep_enable,
	output logic wake_event
);
	logic [3:0] cnt_r = 4'h0;
	initial begin
		{main_osc_in, int_osc_in, pll_in} = 3'h0;
		{wait_for_interrupt_instr, deep_sleep_enable, wake_event} = 3'h0;
	end
	always @(posedge pclk) begin
		cnt_r <= cnt_r + 4'h1;
		main_osc_in <= main_osc_power_down ? 1'b0 : cnt_r[3];
		int_osc_in <= int_osc_stop ? 1'b0 : cnt_r[2];
		pll_in <= pll_power_down ? 1'b0 : cnt_r[1];
	end
	task automatic sleep(input logic deep);
		@(posedge pclk);
		deep_sleep_enable <= deep;
		@(posedge pclk);
		wait_for_interrupt_instr <= 1'b1;
		@(posedge pclk);
		wait_for_interrupt_instr <= 1'b0;
	endtask
	task automatic wake();
		@(posedge pclk);
		wake_event <= 1'b1;
		@(posedge pclk);
		wake_event <= 1'b0;
		deep_sleep_enable <= 1'b0;
	endtask
endmodule

// ### bench/tb_system_clock_power_control.sv
// Self-checking bench for the clock and power control block
`timescale 1ns/10ps
`define CHK(nm, x, g) begin n_tests++; if ((g) !== (x)) begin errors++; \
	$display("Error %s expected %h seen %h", nm, x, g); end end
`define WAITC(c) begin for (k = 0; k < 3000 && (c) !== 1'b1; k++) @(negedge pclk); \
	if ((c) !== 1'b1) tmo(); end
module tb_system_clock_power_control import scpc_pkg::*; ;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, regulator_unregulated = 0, int_stop = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hB4C9;
	logic pready, pslverr, main_osc_in, int_osc_in, pll_in, wait_for_interrupt_instr, deep_sleep_enable;
	logic wake_event, core_clk_en, pll_power_down, pll_output_enable, main_osc_power_down, sys_reset_req;
	logic clk_fail_irq, adc_clk_tick;
	scpc_clk_sel_t sys_clk_sel;
	logic [2:0][31:0] periph_clk_en;
	logic [5:0] regulator_voltage_adjust;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [7:0] ticks;
	int errors = 0, n_tests = 0, k;
	logic [11:0] ra[8] = '{12'h010, 12'h014, 12'h01C, 12'h060, 12'h100, 12'h110, 12'h144, 12'h034};
	logic [31:0] rv[8] = '{32'h000132BF, 32'h01071013, 32'h0000001F, 32'h07A03AD1, 32'h00000040, 32'h00000040,
		32'h07800000, 32'h00000000};
	always #5 pclk = ~pclk;
	scpc_top #(.RELOCK_LOAD(16)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .main_osc_in, .int_osc_in, .pll_in, .regulator_unregulated, .wait_for_interrupt_instr,
		.deep_sleep_enable, .wake_event, .sys_clk_sel, .core_clk_en, .periph_clk_en, .pll_power_down,
		.pll_output_enable, .main_osc_power_down, .regulator_voltage_adjust, .sys_reset_req, .clk_fail_irq,
		.adc_clk_tick);
	scpc_core_model i_core (.pclk, .pll_power_down, .main_osc_power_down, .int_osc_stop(int_stop), .main_osc_in,
		.int_osc_in, .pll_in, .wait_for_interrupt_instr, .deep_sleep_enable, .wake_event);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction
	task automatic final_report();
		$display("Checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tmo();
		errors++;
		$display("Error wait expected done seen timeout");
		final_report();
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) tmo();
		rd = prdata;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [32:0] x);
		q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	always @(posedge pclk) if (psel && penable && pready && !pwrite && q.size() > 0) begin
		e = q.pop_front();
		`CHK("read", e, {pslverr, prdata})
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		`CHK("clock select", {2'h1, 7'h01, 1'b1}, sys_clk_sel)
		`CHK("pll down", 1'b1, pll_power_down)
		apb(1'b1, 12'h010, 32'h0);
		foreach (ra[i]) rchk(ra[i], {1'b0, rv[i]});
		rchk(12'h200, {1'b1, 32'h0});
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 12'h100 + 12'(4 * i), 32'hFFFFFFFF);
			rchk(12'h100 + 12'(4 * i), {1'b0, rv[i]});
		end
		seed = xs(seed);
		apb(1'b1, 12'h034, seed);
		rchk(12'h034, {1'b0, 26'h0, seed[5:0]});
		`CHK("voltage", seed[5:0], regulator_voltage_adjust)
		$display("Test registers done");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, 12'h060, i ? 32'h0FA03AD1 : 32'h07A03AD1);
			`CHK("run gates", 32'h000132BF, periph_clk_en[0])
			i_core.sleep(1'b0);
			`WAITC(core_clk_en === 1'b0)
			repeat (2) @(negedge pclk);
			`CHK("sleep gates", i ? 32'h00000040 : 32'h000132BF, periph_clk_en[0])
			`CHK("sleep clock", {2'h1, 7'h01, 1'b1}, sys_clk_sel)
			i_core.wake();
			`WAITC(core_clk_en === 1'b1)
		end
		$display("Test sleep done");
		apb(1'b1, 12'h060, 32'h07A03AD5);
		@(posedge pclk);
		int_stop <= 1'b1;
		`WAITC(clk_fail_irq === 1'b1)
		`WAITC(sys_clk_sel === {2'h0, 7'h01, 1'b1})
		apb(1'b1, 12'h060, 32'h07A03AD1);
		int_stop <= 1'b0;
		repeat (50) @(negedge pclk);
		`CHK("forced source", 2'h0, sys_clk_sel.src)
		rchk(12'h050, {1'b0, 32'h00000200});
		apb(1'b1, 12'h150, 32'h1);
		`WAITC(clk_fail_irq === 1'b0)
		`WAITC(sys_clk_sel === {2'h1, 7'h01, 1'b1})
		$display("Test failover done");
		apb(1'b1, 12'h160, 32'h1);
		@(posedge pclk);
		regulator_unregulated <= 1'b1;
		`WAITC(sys_reset_req === 1'b1)
		@(posedge pclk);
		regulator_unregulated <= 1'b0;
		`WAITC(sys_reset_req === 1'b0)
		rchk(12'h160, 33'h0);
		$display("Test regulator done");
		apb(1'b1, 12'h060, 32'h07A00AC1);
		rchk(12'h064, {1'b0, 32'h000006C1});
		rchk(12'h050, 33'h0);
		rd = 32'h0;
		for (k = 0; k < 400 && rd[6] !== 1'b1; k++) apb(1'b0, 12'h050, 32'h0);
		if (rd[6] !== 1'b1) tmo();
		apb(1'b1, 12'h060, 32'h07A002C1);
		`WAITC(sys_clk_sel.src === 2'h3 && sys_clk_sel.run === 1'b1)
		`CHK("pll output", 1'b1, pll_output_enable)
		apb(1'b1, 12'h060, 32'h07A002C1);
		rchk(12'h050, {1'b0, 32'h00000040});
		apb(1'b1, 12'h060, 32'h07A00281);
		rchk(12'h050, 33'h0);
		`WAITC(sys_clk_sel.src === 2'h0)
		`WAITC(sys_clk_sel.src === 2'h3 && sys_clk_sel.run === 1'b1)
		ticks = 8'h00;
		repeat (480) begin
			@(negedge pclk);
			ticks += {7'h0, adc_clk_tick};
		end
		`CHK("adc ticks", 8'h0A, ticks)
		$display("Test pll done");
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, 12'h144, i ? 32'h07800010 : 32'h07800000);
			i_core.sleep(1'b1);
			`WAITC(sys_clk_sel === {i ? 2'h1 : 2'h0, i ? 7'h40 : 7'h10, 1'b1})
			`CHK("pll down", 1'b1, pll_power_down)
			`CHK("main down", i ? 1'b1 : 1'b0, main_osc_power_down)
			`CHK("deep gates", 32'h000132BF, periph_clk_en[0])
			`CHK("run gates 1", 32'h01071013, periph_clk_en[1])
			i_core.wake();
			`WAITC(core_clk_en === 1'b1)
			`CHK("wake source", 2'h3, sys_clk_sel.src)
		end
		$display("Test deep sleep done");
		final_report();
	end
endmodule
